// >>> include/dma_test_pkg.sv
// Constants shared by the DMA FIFO test register bank and its host-side driver.
// Summary of operation
// R1 - Acknowledge status reads one when acknowledge inactive.
// R2 - Upper nibble of test three reports revision.
// R3 - Flush moves FIFO to memory until software clears.
// R4 - FIFO byte flags readable during flush.
// R5 - Clear bit empties FIFO pointers, then self-clears.
// R6 - Pin mode limits fetch indicator to opcode phase.
// R7 - Write-invalidate enable gates that bus command.
// R8 - Return address captured on call, restored on return.
// R9 - Return address kept during memory-to-memory moves.
// R10 - Host never writes return address while running.
// R11 - Ten-bit offset counter split across two registers.
// R12 - Software computes residue with 7Fh or 3FFh mask.
// R13 - Burst inhibit forces single cycles everywhere.
// R14 - All-pins float bit tri-states every output.
// R15 - Storage data float tri-states data and parity.
// R16 - Shadow mode redirects return and base registers.
// R17 - Parity check enable gates master parity interrupt.
// R18 - Target reports write parity errors by PERR#.
// R19 - Lane select picks FIFO lane when top set.
// R20 - Address step advances pointer, then self-clears.
// R21 - Count step decrements counter, then self-clears.
// R22 - Depth select chooses 88 or 536 bytes.
// R23 - Lane port writes FIFO top, reads bottom.
// R24 - Direction bit sets or clears direction per polarity.
package dma_test_pkg;
    localparam logic [7:0] test_three_off   = 8'h1b;
    localparam logic [7:0] return_addr_off  = 8'h1c;
    localparam logic [7:0] offset_low_off   = 8'h20;
    localparam logic [7:0] test_four_off    = 8'h21;
    localparam logic [7:0] test_five_off    = 8'h22;
    localparam logic [7:0] lane_port_off    = 8'h23;
    localparam logic [7:0] structure_off    = 8'h10;
    localparam logic [7:0] test_two_off     = 8'h1a;
    localparam logic [7:0] test_one_off     = 8'h19;
    localparam logic [3:0] revision_value   = 4'h1;
    localparam int         flush_bit        = 3;
    localparam int         clear_bit        = 2;
    localparam int         pin_mode_bit     = 1;
    localparam int         invalidate_bit   = 0;
    localparam int         burst_bit        = 7;
    localparam int         float_all_bit    = 6;
    localparam int         float_data_bit   = 5;
    localparam int         shadow_bit       = 4;
    localparam int         parity_bit       = 3;
    localparam int         lane_top_bit     = 2;
    localparam int         addr_step_bit    = 7;
    localparam int         count_step_bit   = 6;
    localparam int         depth_bit        = 5;
    localparam int         polarity_bit     = 4;
    localparam int         direction_bit    = 3;
    localparam logic [7:0] test_four_reset  = 8'h00;
    localparam logic [3:0] test_three_reset = 4'h0;
    localparam int         small_depth      = 88;
    localparam int         large_depth      = 536;
    localparam logic [9:0] small_mask       = 10'h07f;
    localparam logic [9:0] large_mask       = 10'h3ff;
    localparam int         fifo_words       = 134;
endpackage : dma_test_pkg

// >>> include/reg_link_if.sv
// Register access link between the host driver and the test register bank.
`timescale 1ns/10ps
interface reg_link_if;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        ack;
    modport dev  (input addr, input wdata, input wstrb, input wr, input rd,
                  output rdata, output ack);
    modport host (output addr, output wdata, output wstrb, output wr, output rd,
                  input rdata, input ack);
endinterface : reg_link_if

// >>> rtl/dma_test_host.sv
// Host-side driver issuing single register accesses to the test register bank.
`timescale 1ns/10ps
module dma_test_host
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst,
    // User command port.
    input  wire logic        cmd_valid,
    input  wire logic        cmd_write,
    input  wire logic [7:0]  cmd_addr,
    input  wire logic [31:0] cmd_wdata,
    input  wire logic        device_running,
    output logic             cmd_ready,
    output logic             resp_valid,
    output logic [31:0]      resp_data,
    // Register link.
    reg_link_if.host         bus
);
    typedef enum logic [1:0] {idle_st = 2'b01, wait_st = 2'b10} host_state_e;
    host_state_e state_reg;
    logic        blocked;

    assign blocked   = cmd_write && device_running
                     && cmd_addr == dma_test_pkg::return_addr_off; // R10
    assign cmd_ready = state_reg == idle_st;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg  <= idle_st;
            bus.addr   <= 8'h0;
            bus.wdata  <= 32'h0;
            bus.wstrb  <= 4'h0;
            bus.wr     <= 1'b0;
            bus.rd     <= 1'b0;
            resp_valid <= 1'b0;
            resp_data  <= 32'h0;
        end
        else
        begin
            bus.wr     <= 1'b0;
            bus.rd     <= 1'b0;
            resp_valid <= 1'b0;
            case (state_reg)
                idle_st:
                    if (cmd_valid && blocked)
                        resp_valid <= 1'b1;
                    else if (cmd_valid)
                    begin
                        bus.addr  <= cmd_addr;
                        bus.wdata <= cmd_wdata;
                        bus.wstrb <= 4'hf;
                        bus.wr    <= cmd_write;
                        bus.rd    <= !cmd_write;
                        state_reg <= wait_st;
                    end
                wait_st:
                    if (bus.ack)
                    begin
                        resp_valid <= 1'b1;
                        resp_data  <= bus.rdata;
                        state_reg  <= idle_st;
                    end
                default:
                    state_reg <= idle_st;
            endcase
        end
    end
endmodule : dma_test_host

// >>> rtl/dma_test_regs.sv
// Chip-test and DMA control register bank with its DMA FIFO test path.
`timescale 1ns/10ps
module dma_test_regs
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst,
    // Register link.
    reg_link_if.dev          bus,
    // Core status and events.
    input  wire logic        data_ack_n,
    input  wire logic        call_exec,
    input  wire logic        return_exec,
    input  wire logic        mem_move_active,
    input  wire logic        program_running,
    input  wire logic [31:0] call_return_ptr,
    input  wire logic        core_byte_moved,
    input  wire logic        fetch_cycle,
    input  wire logic        fetch_opcode,
    input  wire logic        invalidate_ok,
    input  wire logic        master_parity_err,
    // Core controls.
    output logic [31:0]      ip_load_value,
    output logic             ip_load,
    output logic             opcode_pin_n,
    output logic             use_invalidate,
    output logic             burst_allow,
    output logic             pins_oe_n,
    output logic             storage_data_oe_n,
    output logic             master_parity_irq,
    output logic             to_host_direction,
    output logic             flush_active,
    output logic             fifo_depth_large,
    output logic [31:0]      next_address_pointer,
    output logic [23:0]      transfer_byte_counter
);
    logic [3:0]  ctl_three_reg;
    logic [7:0]  test_four_reg;
    logic [5:0]  test_five_reg;
    logic [31:0] return_address_reg;
    logic [31:0] shadow_return_address;
    logic [31:0] structure_base_reg;
    logic [31:0] shadow_structure_base;
    logic [9:0]  offset_count_reg;
    logic [31:0] fifo_mem [0:dma_test_pkg::fifo_words-1];
    logic [7:0]  top_ptr_reg;
    logic [7:0]  bot_ptr_reg;
    logic [3:0]  byte_full_reg;
    logic [3:0]  byte_empty_reg;
    logic [1:0]  lane;
    logic        wr_three, wr_four, wr_five, wr_ret, wr_port, wr_base, rd_port;
    logic [2:0]  step_amt;
    logic [31:0] rdata_next;

    assign wr_three = bus.wr && bus.addr == dma_test_pkg::test_three_off;
    assign wr_ret   = bus.wr && bus.addr == dma_test_pkg::return_addr_off;
    assign wr_four  = bus.wr && bus.addr == dma_test_pkg::test_four_off;
    assign wr_five  = bus.wr && bus.addr == dma_test_pkg::test_five_off;
    assign wr_port  = bus.wr && bus.addr == dma_test_pkg::lane_port_off;
    assign rd_port  = bus.rd && bus.addr == dma_test_pkg::lane_port_off;
    assign wr_base  = bus.wr && bus.addr == dma_test_pkg::structure_off;

    // Flush, pin mode and invalidate enable; clear is a one-cycle pulse.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ctl_three_reg <= dma_test_pkg::test_three_reset;
        else if (wr_three)
            ctl_three_reg <= bus.wdata[3:0];
        else
            ctl_three_reg[dma_test_pkg::clear_bit] <= 1'b0; // R5
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            test_four_reg <= dma_test_pkg::test_four_reset; // R17
        else if (wr_four)
            test_four_reg <= bus.wdata[7:0];
    end

    // Test five keeps step, depth, polarity and bit 2; the direction bit only loads to_host_direction.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            test_five_reg <= 6'h00;
        else if (wr_five)
        begin
            test_five_reg[5:4] <= bus.wdata[7:6];
            test_five_reg[3:2] <= bus.wdata[5:4];
            test_five_reg[0]   <= bus.wdata[2];
        end
        else
            test_five_reg[5:4] <= 2'h0; // R20 R21
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            to_host_direction <= 1'b0;
        else if (wr_five && bus.wdata[dma_test_pkg::direction_bit])
            to_host_direction <= test_five_reg[2]; // R24
    end

    assign step_amt = (transfer_byte_counter < 24'h4) ? transfer_byte_counter[2:0]
                    : 3'h4 - {1'b0, next_address_pointer[1:0]};

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            next_address_pointer  <= 32'h0;
            transfer_byte_counter <= 24'h0;
        end
        else
        begin
            if (test_five_reg[5])
                next_address_pointer <= next_address_pointer + {29'h0, step_amt}; // R20
            if (test_five_reg[4])
                transfer_byte_counter <= transfer_byte_counter - {21'h0, step_amt}; // R21
        end
    end

    // Return and base registers with shadows; moves leave the main copy alone.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            return_address_reg    <= 32'h0;
            shadow_return_address <= 32'h0;
            structure_base_reg    <= 32'h0;
            shadow_structure_base <= 32'h0;
        end
        else
        begin
            if (wr_ret && test_four_reg[dma_test_pkg::shadow_bit])
                shadow_return_address <= bus.wdata; // R16
            else if (wr_ret && !program_running)
                return_address_reg <= bus.wdata; // R10
            else if (call_exec && !mem_move_active)
                return_address_reg <= call_return_ptr; // R8 R9
            if (wr_base && test_four_reg[dma_test_pkg::shadow_bit])
                shadow_structure_base <= bus.wdata; // R16
            else if (wr_base)
                structure_base_reg <= bus.wdata;
        end
    end

    assign ip_load       = return_exec; // R8
    assign ip_load_value = return_address_reg;

    // Byte offset counter of core-to-DMA traffic.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            offset_count_reg <= 10'h0;
        else if (ctl_three_reg[dma_test_pkg::clear_bit])
            offset_count_reg <= 10'h0;
        else if (core_byte_moved)
            offset_count_reg <= offset_count_reg + 10'h1; // R11
    end

    assign lane = test_four_reg[dma_test_pkg::lane_top_bit] ? test_four_reg[1:0]
                : next_address_pointer[1:0]; // R19

    // FIFO lane test path: writes fill the top, reads drain the bottom.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            top_ptr_reg     <= 8'h0;
            bot_ptr_reg     <= 8'h0;
            byte_full_reg   <= 4'h0;
            byte_empty_reg  <= 4'hf;
        end
        else if (ctl_three_reg[dma_test_pkg::clear_bit])
        begin
            top_ptr_reg    <= 8'h0; // R5
            bot_ptr_reg    <= 8'h0;
            byte_full_reg  <= 4'h0;
            byte_empty_reg <= 4'hf;
        end
        else
        begin
            if (wr_port)
            begin
                byte_full_reg[lane]  <= 1'b1;
                byte_empty_reg[lane] <= 1'b0;
                if (lane == 2'h3)
                    top_ptr_reg <= top_ptr_reg + 8'h1;
            end
            if (rd_port)
            begin
                byte_empty_reg[lane] <= 1'b1; // R23
                if (lane == 2'h3)
                    bot_ptr_reg <= bot_ptr_reg + 8'h1;
            end
        end
    end

    // The array itself has no reset; a clear only resets the pointers and byte flags.
    always_ff @(posedge clk)
    begin
        if (wr_port && !ctl_three_reg[dma_test_pkg::clear_bit])
            fifo_mem[top_ptr_reg][lane*8 +: 8] <= bus.wdata[7:0]; // R23
    end

    always_comb
    begin
        case (bus.addr)
            dma_test_pkg::test_two_off:
                rdata_next = {31'h0, data_ack_n}; // R1
            dma_test_pkg::test_three_off:
                rdata_next = {24'h0, dma_test_pkg::revision_value, ctl_three_reg}; // R2
            dma_test_pkg::return_addr_off:
                rdata_next = test_four_reg[dma_test_pkg::shadow_bit] ? shadow_return_address
                           : return_address_reg;
            dma_test_pkg::structure_off:
                rdata_next = test_four_reg[dma_test_pkg::shadow_bit] ? shadow_structure_base
                           : structure_base_reg;
            dma_test_pkg::offset_low_off:
                rdata_next = {24'h0, offset_count_reg[7:0]}; // R11
            dma_test_pkg::test_four_off:
                rdata_next = {24'h0, test_four_reg};
            dma_test_pkg::test_five_off:
                rdata_next = {24'h0, test_five_reg[5:4], test_five_reg[3:2],
                              to_host_direction, test_five_reg[0], offset_count_reg[9:8]};
            dma_test_pkg::test_one_off:
                rdata_next = {24'h0, byte_empty_reg, byte_full_reg}; // R4
            default:
                rdata_next = 32'h0;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            bus.rdata <= 32'h0;
            bus.ack   <= 1'b0;
        end
        else
        begin
            bus.ack   <= bus.rd || bus.wr;
            bus.rdata <= rd_port ? {24'h0, fifo_mem[bot_ptr_reg][lane*8 +: 8]} : rdata_next;
        end
    end

    assign flush_active      = ctl_three_reg[dma_test_pkg::flush_bit]; // R3
    assign opcode_pin_n      = !(fetch_cycle && (fetch_opcode
                             || !ctl_three_reg[dma_test_pkg::pin_mode_bit])); // R6
    assign use_invalidate    = invalidate_ok && ctl_three_reg[dma_test_pkg::invalidate_bit]; // R7
    assign burst_allow       = !test_four_reg[dma_test_pkg::burst_bit]; // R13
    assign pins_oe_n         = test_four_reg[dma_test_pkg::float_all_bit]; // R14
    assign storage_data_oe_n = test_four_reg[dma_test_pkg::float_all_bit]
                             || test_four_reg[dma_test_pkg::float_data_bit]; // R15
    assign master_parity_irq = master_parity_err
                             && test_four_reg[dma_test_pkg::parity_bit]; // R17 R18
    assign fifo_depth_large  = test_five_reg[3]; // R22
endmodule : dma_test_regs

// >>> tb/dma_fifo_test_control_regs_test.sv
// Self-checking bench for the test register bank driven through its host driver.
`timescale 1ns/10ps
module dma_fifo_test_control_regs_test;
    logic clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, cmd_write = 1'b0, device_running = 1'b0;
    logic data_ack_n = 1'b1, call_exec = 1'b0, return_exec = 1'b0, mem_move_active = 1'b0;
    logic program_running = 1'b0, core_byte_moved = 1'b0, fetch_cycle = 1'b0;
    logic fetch_opcode = 1'b0, invalidate_ok = 1'b0, master_parity_err = 1'b0;
    logic [7:0] cmd_addr = 8'h00;
    logic [31:0] cmd_wdata = 32'h0, call_return_ptr = 32'h0, q, ipv, nap;
    logic [23:0] tbc;
    logic cmd_ready, resp_valid, ip_load, opin_n, use_inv, burst_ok, pins_n, sd_n, irq;
    logic to_host, flushing, deep;
    logic [31:0] resp_data;
    int err_total = 0, check_count = 0;

    reg_link_if reg_link_if_inst ();

    always #5 clk = ~clk;

    dma_test_regs dma_test_regs_inst (.clk(clk), .rst(rst), .bus(reg_link_if_inst.dev),
        .data_ack_n(data_ack_n), .call_exec(call_exec), .return_exec(return_exec),
        .mem_move_active(mem_move_active), .program_running(program_running),
        .call_return_ptr(call_return_ptr), .core_byte_moved(core_byte_moved),
        .fetch_cycle(fetch_cycle), .fetch_opcode(fetch_opcode), .invalidate_ok(invalidate_ok),
        .master_parity_err(master_parity_err), .ip_load_value(ipv), .ip_load(ip_load),
        .opcode_pin_n(opin_n), .use_invalidate(use_inv), .burst_allow(burst_ok),
        .pins_oe_n(pins_n), .storage_data_oe_n(sd_n), .master_parity_irq(irq),
        .to_host_direction(to_host), .flush_active(flushing), .fifo_depth_large(deep),
        .next_address_pointer(nap), .transfer_byte_counter(tbc));

    dma_test_host dma_test_host_inst (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .device_running(device_running), .cmd_ready(cmd_ready), .resp_valid(resp_valid),
        .resp_data(resp_data), .bus(reg_link_if_inst.host));

    dma_test_properties dma_test_properties_inst (.clk(clk), .rst(rst),
        .addr(reg_link_if_inst.addr), .wdata(reg_link_if_inst.wdata),
        .wstrb(reg_link_if_inst.wstrb), .wr(reg_link_if_inst.wr), .rd(reg_link_if_inst.rd),
        .rdata(reg_link_if_inst.rdata), .ack(reg_link_if_inst.ack));

    task summarize;
        $display("comparisons %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize

    task chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e)
        begin
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
            err_total++;
        end
    endtask : chk

    // One command through the host driver, bounded waits on its handshake.
    task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_addr  = a;
        cmd_wdata = d;
        while (cmd_ready !== 1'b1 && n < 50)
        begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        cmd_valid = 1'b0;
        while (resp_valid !== 1'b1 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        q = resp_data;
        if (n >= 100)
        begin
            err_total++;
            summarize();
        end
    endtask : acc

    task pulse_sig(input int which);
        @(negedge clk);
        if (which == 0) call_exec = 1'b1; else core_byte_moved = 1'b1;
        @(negedge clk);
        call_exec = 1'b0;
        core_byte_moved = 1'b0;
    endtask : pulse_sig

    initial
    begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        acc(0, dma_test_pkg::test_four_off, 0);
        chk(q[7:0], dma_test_pkg::test_four_reset);
        acc(0, dma_test_pkg::test_three_off, 0);
        chk(q[7:0], {dma_test_pkg::revision_value, 4'h0});
        acc(0, dma_test_pkg::test_two_off, 0);
        chk(q[0], 1'b1);
        data_ack_n = 1'b0;
        acc(0, dma_test_pkg::test_two_off, 0);
        chk(q[0], 1'b0);
        acc(0, 8'h04, 0);
        chk(q, 32'h0);
        $display("test reset values done");
        master_parity_err = 1'b1;
        acc(1, dma_test_pkg::test_four_off, 32'h88);
        chk({burst_ok, irq}, 2'b01);
        acc(1, dma_test_pkg::test_four_off, 32'h60);
        chk({pins_n, sd_n, irq}, 3'b110);
        acc(1, dma_test_pkg::test_four_off, 32'h00);
        chk({burst_ok, pins_n, sd_n, irq}, 4'b1000);
        master_parity_err = 1'b0;
        $display("test control four done");
        invalidate_ok = 1'b1;
        fetch_cycle = 1'b1;
        acc(1, dma_test_pkg::test_three_off, 32'h01);
        chk({use_inv, opin_n}, 2'b10);
        acc(1, dma_test_pkg::test_three_off, 32'h02);
        chk({use_inv, opin_n}, 2'b01);
        fetch_opcode = 1'b1;
        acc(1, dma_test_pkg::test_three_off, 32'h0c);
        chk({opin_n, flushing}, 2'b01);
        acc(0, dma_test_pkg::test_three_off, 0);
        chk(q[3:2], 2'b10);
        acc(0, dma_test_pkg::test_one_off, 0);
        chk(q[7:0], 8'hf0);
        acc(1, dma_test_pkg::test_three_off, 32'h00);
        chk(flushing, 1'b0);
        $display("test control three done");
        call_return_ptr = 32'h1234_5678;
        pulse_sig(0);
        mem_move_active = 1'b1;
        call_return_ptr = 32'h0bad_0bad;
        pulse_sig(0);
        mem_move_active = 1'b0;
        acc(0, dma_test_pkg::return_addr_off, 0);
        chk(q, 32'h1234_5678);
        device_running = 1'b1;
        acc(1, dma_test_pkg::return_addr_off, 32'hffff_ffff);
        device_running = 1'b0;
        acc(0, dma_test_pkg::return_addr_off, 0);
        chk(q, 32'h1234_5678);
        program_running = 1'b1;
        acc(1, dma_test_pkg::return_addr_off, 32'h5555_5555);
        program_running = 1'b0;
        acc(0, dma_test_pkg::return_addr_off, 0);
        chk(q, 32'h1234_5678);
        acc(1, dma_test_pkg::test_four_off, 32'h10);
        acc(1, dma_test_pkg::return_addr_off, 32'h0000_f00d);
        acc(0, dma_test_pkg::return_addr_off, 0);
        chk(q, 32'h0000_f00d);
        acc(1, dma_test_pkg::test_four_off, 32'h00);
        @(negedge clk);
        return_exec = 1'b1;
        #1;
        chk({ip_load, ipv}, {1'b1, 32'h1234_5678});
        @(negedge clk);
        return_exec = 1'b0;
        $display("test return address done");
        repeat (5) pulse_sig(1);
        acc(0, dma_test_pkg::offset_low_off, 0);
        chk(q[7:0], 8'h05);
        chk(({2'h0, q[7:0]} - {3'h0, tbc[6:0]}) & dma_test_pkg::small_mask, 32'h5);
        acc(1, dma_test_pkg::test_five_off, 32'h30);
        acc(1, dma_test_pkg::test_five_off, 32'h38);
        chk({deep, to_host}, 2'b11);
        acc(1, dma_test_pkg::test_five_off, 32'h00);
        acc(1, dma_test_pkg::test_five_off, 32'h08);
        chk({deep, to_host}, 2'b00);
        acc(1, dma_test_pkg::test_five_off, 32'hc0);
        acc(0, dma_test_pkg::test_five_off, 0);
        chk(q[7:6], 2'b00);
        chk({nap[7:0], tbc}, 32'h0);
        $display("test control five done");
        for (int i = 0; i < 4; i++)
        begin
            acc(1, dma_test_pkg::test_four_off, 32'h04 | i);
            acc(1, dma_test_pkg::lane_port_off, 32'hb0 + i);
        end
        for (int i = 0; i < 4; i++)
        begin
            acc(1, dma_test_pkg::test_four_off, 32'h04 | i);
            acc(0, dma_test_pkg::lane_port_off, 0);
            chk(q[7:0], 8'hb0 + i[7:0]);
        end
        $display("test lane port done");
        summarize();
    end
endmodule : dma_fifo_test_control_regs_test

// >>> tb/dma_test_properties.sv
// Interface checks for the link between the host driver and the test register bank.
`timescale 1ns/10ps
module dma_test_properties
(
    // Clock and reset.
    input wire logic        clk,
    input wire logic        rst,
    // Link signals.
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic [3:0]  wstrb,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    input wire logic        ack
);
    logic [7:0] four_copy_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Tracks the last value written to test register four.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            four_copy_reg <= dma_test_pkg::test_four_reset;
        else if (wr && addr == dma_test_pkg::test_four_off)
            four_copy_reg <= wdata[7:0];
    end

    sequence s_access;
        wr || rd;
    endsequence
    sequence s_quiet;
        !(wr || rd) [*3];
    endsequence

    a_ack_follows_req: assert property (s_access |=> ack and s_quiet)
        else $error("access not answered once");
    a_ack_has_cause: assert property (ack |-> $past(wr || rd))
        else $error("answer without access");
    a_single_access: assert property (!(wr && rd))
        else $error("read and write together");
    a_full_strobe: assert property (wr |-> wstrb == 4'hf)
        else $error("partial strobe");
    a_revision_read: assert property (
        rd && addr == dma_test_pkg::test_three_off |=> rdata[7:4] == dma_test_pkg::revision_value)
        else $error("revision nibble wrong");
    a_clear_self_ends: assert property (
        rd && addr == dma_test_pkg::test_three_off |=> rdata[2] == 1'b0)
        else $error("clear bit still set");
    a_step_self_ends: assert property (
        rd && addr == dma_test_pkg::test_five_off |=> rdata[7:6] == 2'b00)
        else $error("step bit still set");
    a_four_read_back: assert property (
        rd && addr == dma_test_pkg::test_four_off |=> rdata[7:0] == $past(four_copy_reg))
        else $error("test four read back wrong");
    a_unmapped_zero: assert property (rd && addr < 8'h10 |=> rdata == 32'h0000_0000)
        else $error("unmapped read not zero");
endmodule : dma_test_properties
